// ===== verilog/utxrx_top.sv
// Asynchronous serial transceiver with 16x oversampled receiver and address filter
//
// Function
// - Idle transmitter loads shifter on write
// - Busy transmitter defers load past stop
// - Buffer-to-shifter transfer sets empty flag
// - Frame: start bit zero, stop bit one
// - Send start, data LSB first, stop
// - Empty flag stays set until written
// - Done flag after stop bit time
// - Transmit enable owns output pin
// - Receiver samples at sixteen times baud
// - Reject start bit on majority one
// - Data bits majority of samples 7-9
// - Zero stop majority sets framing error
// - Character moves to receive buffer unless filtered out or buffer still full
// - Data address: read receive, write transmit
// - Overrun drops character, shows after read
// - Receive enable forces pin to input
// - Nine-bit mode carries ninth data bit
// - Ninth or stop bit marks address
// - Address filter ignores data characters
// - Stop bit one clears framing error
// - Reading receive buffer clears done flag
// - Done flag cleared by ack or one
// - Empty flag set during reset
//
// Added by the designer: strobed register access and the register offsets.
`include "utxrx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module utxrx_top (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic [`UTXRX_ADDR_W-1:0]  i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [7:0]                o_rdata,
    input  wire logic                      i_tx_done_ack,
    input  wire logic                      i_rx_port_pin,
    input  wire logic                      i_tx_pin_direction_bit,
    input  wire logic                      i_tx_port_bit,
    input  wire logic                      i_rx_pin_direction_bit,
    input  wire logic                      i_rx_pin_pullup_bit,
    output logic                           o_tx_port_pin,
    output logic                           o_tx_pin_oe,
    output logic                           o_rx_pin_oe,
    output logic                           o_rx_pin_pullup,
    output logic                           o_irq_rx_done,
    output logic                           o_irq_tx_done,
    output logic                           o_irq_tx_empty
);
    // Register file
    logic [7:0]              ctrl_reg, ctrl_next;
    logic [`UTXRX_DIV_W-1:0] div_reg, div_next;
    logic                    filt_reg, filt_next;
    logic                    tx_done_reg, tx_done_next;
    logic                    tx_empty_reg, tx_empty_next;
    logic [7:0]              tx_buf_reg, tx_buf_next;
    logic                    tx_buf_b9_reg, tx_buf_b9_next;
    logic [7:0]              rdata_reg, rdata_next;

    // Tick divider
    logic [`UTXRX_DIV_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic                    tick;

    // Transmitter
    utxrx_pkg::utxrx_tx_state_t tx_st_reg, tx_st_next;
    logic [10:0]             tx_sh_reg, tx_sh_next;
    logic [3:0]              tx_bits_reg, tx_bits_next;
    logic [3:0]              tx_sub_reg, tx_sub_next;
    logic                    tx_out_reg, tx_out_next;

    // Receiver
    utxrx_pkg::utxrx_rx_state_t rx_st_reg, rx_st_next;
    logic [3:0]              rx_sub_reg, rx_sub_next;
    logic [3:0]              rx_bits_reg, rx_bits_next;
    logic [9:0]              rx_sh_reg, rx_sh_next;
    logic [2:0]              rx_vote_reg, rx_vote_next;
    logic [7:0]              rx_buf_reg, rx_buf_next;
    logic                    rx_b9_reg, rx_b9_next;
    logic                    rx_done_reg, rx_done_next;
    logic                    ferr_reg, ferr_next;
    logic                    ovr_reg, ovr_next;
    logic                    ovr_pend_reg, ovr_pend_next;

    // Output flops
    logic                    pin_oe_reg, rx_oe_reg, pullup_reg, irq_rx_reg, irq_tx_reg, irq_em_reg;

    logic                    transmitter_enable, receiver_enable, nine, wr_data, rd_data;
    logic                    maj, stop_bit, is_addr;
    logic [3:0]              nbits;

    assign transmitter_enable    = ctrl_reg[`UTXRX_CSB_TRANSMITTER_ENABLE];
    assign receiver_enable    = ctrl_reg[`UTXRX_CSB_RECEIVER_ENABLE];
    assign nine    = ctrl_reg[`UTXRX_CSB_NINE];
    assign wr_data = i_wr && (i_addr == `UTXRX_OFF_DATA);
    assign rd_data = i_rd && (i_addr == `UTXRX_OFF_DATA);
    // Start + data + stop, plus the ninth bit in nine-bit mode, counted from the start bit
    assign nbits   = nine ? 4'hB : 4'hA;
    assign maj     = (rx_vote_reg[0] & rx_vote_reg[1]) | (rx_vote_reg[0] & rx_vote_reg[2]) |
                     (rx_vote_reg[1] & rx_vote_reg[2]);

    // Sixteen-times-baud tick; divider value N gives N+1 clocks per tick
    always_comb begin
        tick          = (tick_cnt_reg == div_reg);
        tick_cnt_next = tick ? `UTXRX_DIV_RESET : tick_cnt_reg + 1'b1;
    end

    // Transmitter
    always_comb begin
        tx_st_next     = tx_st_reg;
        tx_sh_next     = tx_sh_reg;
        tx_bits_next   = tx_bits_reg;
        tx_sub_next    = tx_sub_reg;
        tx_out_next    = tx_out_reg;
        tx_empty_next  = tx_empty_reg;
        tx_done_next   = tx_done_reg;
        tx_buf_next    = tx_buf_reg;
        tx_buf_b9_next = tx_buf_b9_reg;
        if (wr_data) begin
            tx_buf_next    = i_wdata;
            tx_buf_b9_next = ctrl_reg[`UTXRX_CSB_TXB9];
            tx_empty_next  = 1'b0;
        end
        if (i_tx_done_ack || (i_wr && i_addr == `UTXRX_OFF_CSA && i_wdata[`UTXRX_CSA_TXDONE])) begin
            tx_done_next = 1'b0;
        end
        case (tx_st_reg)
            utxrx_pkg::TX_IDLE: begin
                tx_out_next = 1'b1;
                // A character left in the buffer waits until the transmitter is enabled
                if (!tx_empty_reg && transmitter_enable) begin
                    tx_sh_next    = nine ? {1'b1, tx_buf_b9_reg, tx_buf_reg, 1'b0}
                                         : {2'b11, tx_buf_reg, 1'b0};
                    tx_empty_next = 1'b1;
                    tx_bits_next  = 4'h0;
                    tx_sub_next   = 4'h0;
                    tx_st_next    = utxrx_pkg::TX_SHIFT;
                end
            end
            utxrx_pkg::TX_SHIFT: begin
                if (tick) begin
                    tx_sub_next = tx_sub_reg + 1'b1;
                    if (tx_sub_reg == 4'h0) begin
                        tx_out_next = tx_sh_reg[0];
                        tx_sh_next  = {1'b1, tx_sh_reg[10:1]};
                    end
                    if (tx_sub_reg == `UTXRX_SMP_LAST) begin
                        tx_bits_next = tx_bits_reg + 1'b1;
                        if (tx_bits_reg == nbits - 1'b1) begin
                            // Stop bit has stood one bit time
                            tx_st_next = utxrx_pkg::TX_IDLE;
                            if (tx_empty_reg && !wr_data) begin
                                tx_done_next = 1'b1;
                            end
                        end
                    end
                end
            end
            default: tx_st_next = utxrx_pkg::TX_IDLE;
        endcase
    end

    // Receiver
    always_comb begin
        rx_st_next    = rx_st_reg;
        rx_sub_next   = rx_sub_reg;
        rx_bits_next  = rx_bits_reg;
        rx_sh_next    = rx_sh_reg;
        rx_vote_next  = rx_vote_reg;
        rx_buf_next   = rx_buf_reg;
        rx_b9_next    = rx_b9_reg;
        rx_done_next  = rx_done_reg;
        ferr_next     = ferr_reg;
        ovr_next      = ovr_reg;
        ovr_pend_next = ovr_pend_reg;
        stop_bit      = maj;
        is_addr       = nine ? rx_sh_reg[9] : maj;
        if (rd_data) begin
            rx_done_next  = 1'b0;
            ovr_next      = ovr_pend_reg;
            ovr_pend_next = 1'b0;
        end
        if (tick && receiver_enable) begin
            rx_sub_next = rx_sub_reg + 1'b1;
            if (rx_sub_reg == `UTXRX_SMP_A || rx_sub_reg == `UTXRX_SMP_B || rx_sub_reg == `UTXRX_SMP_C) begin
                rx_vote_next = {rx_vote_reg[1:0], i_rx_port_pin};
            end
            case (rx_st_reg)
                utxrx_pkg::RX_IDLE: begin
                    rx_sub_next = 4'h1;
                    if (!i_rx_port_pin) begin
                        rx_st_next = utxrx_pkg::RX_START;
                    end
                end
                utxrx_pkg::RX_START: begin
                    if (rx_sub_reg == `UTXRX_SMP_LAST) begin
                        rx_bits_next = 4'h1;
                        rx_st_next   = maj ? utxrx_pkg::RX_IDLE : utxrx_pkg::RX_DATA;
                    end
                end
                utxrx_pkg::RX_DATA: begin
                    if (rx_sub_reg == `UTXRX_SMP_LAST) begin
                        rx_bits_next = rx_bits_reg + 1'b1;
                        if (rx_bits_reg != nbits - 1'b1) begin
                            rx_sh_next = {maj, rx_sh_reg[9:1]};
                        end else begin
                            rx_st_next = utxrx_pkg::RX_IDLE;
                            if (!filt_reg || is_addr) begin
                                if (rx_done_reg && !rd_data) begin
                                    ovr_pend_next = 1'b1;
                                end else begin
                                    rx_buf_next  = nine ? rx_sh_reg[8:1] : rx_sh_reg[9:2];
                                    rx_b9_next   = nine ? rx_sh_reg[9] : rx_b9_reg;
                                    rx_done_next = 1'b1;
                                    ovr_next     = ovr_pend_reg && !rd_data;
                                    ferr_next    = !stop_bit;
                                end
                            end
                        end
                    end
                end
                default: rx_st_next = utxrx_pkg::RX_IDLE;
            endcase
        end else if (!receiver_enable) begin
            rx_st_next = utxrx_pkg::RX_IDLE;
        end
    end

    // Register writes and reads
    always_comb begin
        ctrl_next  = ctrl_reg;
        div_next   = div_reg;
        filt_next  = filt_reg;
        rdata_next = 8'h00;
        if (i_wr) begin
            case (i_addr)
                `UTXRX_OFF_CSA: filt_next = i_wdata[`UTXRX_CSA_ADDRFILT];
                `UTXRX_OFF_CSB: ctrl_next = {i_wdata[7:2], ctrl_reg[`UTXRX_CSB_RXB9], i_wdata[0]};
                `UTXRX_OFF_DIV: div_next  = {i_wdata, div_reg[3:0]};
                default: ;
            endcase
        end
        ctrl_next[`UTXRX_CSB_RXB9] = rx_b9_next;
        if (i_rd) begin
            case (i_addr)
                `UTXRX_OFF_DATA: rdata_next = rx_buf_reg;
                `UTXRX_OFF_CSA:  rdata_next = {rx_done_reg, tx_done_reg, tx_empty_reg, ferr_reg, ovr_reg,
                                               2'b00, filt_reg};
                `UTXRX_OFF_CSB:  rdata_next = {ctrl_reg[7:1], 1'b0};
                `UTXRX_OFF_DIV:  rdata_next = div_reg[11:4];
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg      <= `UTXRX_CSB_RESET;
            div_reg       <= `UTXRX_DIV_RESET;
            filt_reg      <= 1'b0;
            tx_done_reg   <= 1'b0;
            tx_empty_reg  <= 1'b1;
            tx_buf_reg    <= 8'h00;
            tx_buf_b9_reg <= 1'b0;
            rdata_reg     <= 8'h00;
            tick_cnt_reg  <= `UTXRX_DIV_RESET;
            tx_st_reg     <= utxrx_pkg::TX_IDLE;
            tx_sh_reg     <= 11'h7FF;
            tx_bits_reg   <= 4'h0;
            tx_sub_reg    <= 4'h0;
            tx_out_reg    <= 1'b1;
            rx_st_reg     <= utxrx_pkg::RX_IDLE;
            rx_sub_reg    <= 4'h0;
            rx_bits_reg   <= 4'h0;
            rx_sh_reg     <= 10'h000;
            rx_vote_reg   <= 3'h7;
            rx_buf_reg    <= 8'h00;
            rx_b9_reg     <= 1'b1;
            rx_done_reg   <= 1'b0;
            ferr_reg      <= 1'b0;
            ovr_reg       <= 1'b0;
            ovr_pend_reg  <= 1'b0;
            pin_oe_reg    <= 1'b0;
            rx_oe_reg     <= 1'b0;
            pullup_reg    <= 1'b0;
            irq_rx_reg    <= 1'b0;
            irq_tx_reg    <= 1'b0;
            irq_em_reg    <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            div_reg       <= div_next;
            filt_reg      <= filt_next;
            tx_done_reg   <= tx_done_next;
            tx_empty_reg  <= tx_empty_next;
            tx_buf_reg    <= tx_buf_next;
            tx_buf_b9_reg <= tx_buf_b9_next;
            rdata_reg     <= rdata_next;
            tick_cnt_reg  <= tick_cnt_next;
            tx_st_reg     <= tx_st_next;
            tx_sh_reg     <= tx_sh_next;
            tx_bits_reg   <= tx_bits_next;
            tx_sub_reg    <= tx_sub_next;
            tx_out_reg    <= transmitter_enable ? tx_out_next : i_tx_port_bit;
            rx_st_reg     <= rx_st_next;
            rx_sub_reg    <= rx_sub_next;
            rx_bits_reg   <= rx_bits_next;
            rx_sh_reg     <= rx_sh_next;
            rx_vote_reg   <= rx_vote_next;
            rx_buf_reg    <= rx_buf_next;
            rx_b9_reg     <= rx_b9_next;
            rx_done_reg   <= rx_done_next;
            ferr_reg      <= ferr_next;
            ovr_reg       <= ovr_next;
            ovr_pend_reg  <= ovr_pend_next;
            pin_oe_reg    <= transmitter_enable | i_tx_pin_direction_bit;
            rx_oe_reg     <= !receiver_enable && i_rx_pin_direction_bit;
            pullup_reg    <= i_rx_pin_pullup_bit;
            irq_rx_reg    <= rx_done_next && ctrl_next[`UTXRX_CSB_RXIE];
            irq_tx_reg    <= tx_done_next && ctrl_next[`UTXRX_CSB_TXIE];
            irq_em_reg    <= tx_empty_next && ctrl_next[`UTXRX_CSB_EMPTYIE];
        end
    end

    assign o_rdata         = rdata_reg;
    assign o_tx_port_pin   = tx_out_reg;
    assign o_tx_pin_oe     = pin_oe_reg;
    assign o_rx_pin_oe     = rx_oe_reg;
    assign o_rx_pin_pullup = pullup_reg;
    assign o_irq_rx_done   = irq_rx_reg;
    assign o_irq_tx_done   = irq_tx_reg;
    assign o_irq_tx_empty  = irq_em_reg;
endmodule // utxrx_top

`default_nettype wire

// ===== verilog/utxrx_consts.svh
// Register offsets, field positions, reset values and timing counts of the serial transceiver
`ifndef UTXRX_CONSTS_SVH
`define UTXRX_CONSTS_SVH

`define UTXRX_ADDR_W            3
`define UTXRX_OFF_DATA          3'h0
`define UTXRX_OFF_CSA           3'h1
`define UTXRX_OFF_CSB           3'h2
`define UTXRX_OFF_DIV           3'h3

`define UTXRX_CSA_RXDONE        7
`define UTXRX_CSA_TXDONE        6
`define UTXRX_CSA_TXEMPTY       5
`define UTXRX_CSA_FRAMERR       4
`define UTXRX_CSA_OVERRUN       3
`define UTXRX_CSA_ADDRFILT      0

`define UTXRX_CSB_RXIE          7
`define UTXRX_CSB_TXIE          6
`define UTXRX_CSB_EMPTYIE       5
`define UTXRX_CSB_RECEIVER_ENABLE          4
`define UTXRX_CSB_TRANSMITTER_ENABLE          3
`define UTXRX_CSB_NINE          2
`define UTXRX_CSB_RXB9          1
`define UTXRX_CSB_TXB9          0

`define UTXRX_CSB_RESET         8'h02
`define UTXRX_DIV_W             12
`define UTXRX_DIV_RESET         12'h000
`define UTXRX_OVERSAMPLE        16
`define UTXRX_SMP_A             4'h7
`define UTXRX_SMP_B             4'h8
`define UTXRX_SMP_C             4'h9
`define UTXRX_SMP_LAST          4'hF

`endif

// ===== verilog/utxrx_pkg.sv
// Types of the serial transceiver
package utxrx_pkg;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01
    } utxrx_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } utxrx_rx_state_t;
endpackage

// ===== verification/utxrx_monitor.sv
// Port-level checker of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "utxrx_consts.svh"
module utxrx_monitor (
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire logic [`UTXRX_ADDR_W-1:0] i_addr,
    input wire logic [7:0]               i_wdata,
    input wire logic                     i_wr,
    input wire logic                     i_rd,
    input wire logic                     i_tx_done_ack,
    input wire logic [7:0]               o_rdata,
    input wire logic                     o_tx_port_pin,
    input wire logic                     o_tx_pin_oe,
    input wire logic                     o_rx_pin_oe,
    input wire logic                     o_irq_rx_done,
    input wire logic                     o_irq_tx_done,
    input wire logic                     o_irq_tx_empty
);
    logic [7:0] csb_reg, csb_next;
    logic [7:0] low_reg, low_next;
    // Shadow of control B and length of the current low run on the line
    always_comb begin
        csb_next = (i_wr && i_addr == `UTXRX_OFF_CSB) ? i_wdata : csb_reg;
        low_next = (o_tx_port_pin || !csb_reg[`UTXRX_CSB_TRANSMITTER_ENABLE]) ? 8'h00 : low_reg + 8'h01;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            csb_reg <= 8'h00;
            low_reg <= 8'h00;
        end else begin
            csb_reg <= csb_next;
            low_reg <= low_next;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property ($past(i_rd) && $past(i_addr) > `UTXRX_OFF_DIV |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_tx_pin_owned: assert property ($past(csb_reg[`UTXRX_CSB_TRANSMITTER_ENABLE]) |-> o_tx_pin_oe)
        else $error("tx pin not driven while enabled");
    a_rx_pin_input: assert property ($past(csb_reg[`UTXRX_CSB_RECEIVER_ENABLE]) |-> !o_rx_pin_oe)
        else $error("rx pin driven while receiving");
    a_bit_time_len: assert property ($rose(o_tx_port_pin) && low_reg != 8'h00 |-> low_reg[3:0] == 4'h0)
        else $error("low run not whole bit times");
    // Interrupt flops take the enable of the same write edge, so the updated shadow is the gate
    a_irq_rx_gate: assert property (!csb_reg[`UTXRX_CSB_RXIE] |-> !o_irq_rx_done)
        else $error("rx irq without enable");
    a_irq_tx_gate: assert property (!csb_reg[`UTXRX_CSB_TXIE] |-> !o_irq_tx_done)
        else $error("tx irq without enable");
    a_irq_empty_gate: assert property (!csb_reg[`UTXRX_CSB_EMPTYIE] |-> !o_irq_tx_empty)
        else $error("empty irq without enable");
    a_ack_clears_done: assert property (i_tx_done_ack |-> ##2 !o_irq_tx_done)
        else $error("ack did not clear tx done");
    c_rx_irq: cover property (o_irq_rx_done);
    c_tx_irq: cover property (o_irq_tx_done);
    c_long_low: cover property ($rose(o_tx_port_pin) && low_reg > 8'h10);
endmodule // utxrx_monitor
`default_nettype wire

// ===== verification/utxrx_remote.sv
// Remote serial transceiver on the line side
`timescale 1ns/1ps
`default_nettype none
module utxrx_remote (
    input  wire logic i_clk,
    input  wire logic i_line,
    input  wire logic i_nine,
    output logic      o_line
);
    logic [9:0] got_q[$];
    logic [9:0] bits;
    int         i;
    // The line idles at mark level between frames
    initial o_line = 1'b1;
    task automatic send(input logic [10:0] f, input int len);
        for (int k = 0; k < len; k++) begin
            o_line <= f[k];
            repeat (16) @(posedge i_clk);
        end
        o_line <= 1'b1;
    endtask
    task automatic spike(input int n);
        o_line <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_line <= 1'b1;
    endtask
    // Samples mid-bit; keeps data bits and stop bit, LSB first
    always begin
        @(posedge i_clk);
        if (i_line === 1'b0) begin
            repeat (8) @(posedge i_clk);
            bits = 10'h000;
            for (i = 0; i <= (i_nine ? 9 : 8); i++) begin
                repeat (16) @(posedge i_clk);
                bits[i] = i_line;
            end
            got_q.push_back(bits);
        end
    end
endmodule // utxrx_remote
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "utxrx_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk, rst, wr, rd, ack, rx_line, tx_dir, tx_bit, rx_dir, pull_bit, nine;
    logic tx_line, tx_oe, rx_oe, pull, irq_rx, irq_tx, irq_em;
    logic [`UTXRX_ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata;
    int bad_count, tests_run, cyc;
    utxrx_top utxrx_top_i (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_tx_done_ack(ack), .i_rx_port_pin(rx_line),
        .i_tx_pin_direction_bit(tx_dir), .i_tx_port_bit(tx_bit), .i_rx_pin_direction_bit(rx_dir),
        .i_rx_pin_pullup_bit(pull_bit), .o_tx_port_pin(tx_line), .o_tx_pin_oe(tx_oe),
        .o_rx_pin_oe(rx_oe), .o_rx_pin_pullup(pull), .o_irq_rx_done(irq_rx),
        .o_irq_tx_done(irq_tx), .o_irq_tx_empty(irq_em));
    utxrx_remote utxrx_remote_i (.i_clk(clk), .i_line(tx_line), .i_nine(nine), .o_line(rx_line));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end
    task wr_reg(input logic [`UTXRX_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task rd_chk(input logic [`UTXRX_ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task wait_tx(input int n);
        for (int c = 0; c < 4000 && utxrx_remote_i.got_q.size() < n; c++) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask
    task fchk(input logic [9:0] e);
        logic [9:0] g;
        g = utxrx_remote_i.got_q.pop_front();
        `CHK(g, e)
    endtask
    // Frame is start at bit 0, then data, then stop; blocks until the stop bit is out
    task rx(input logic [10:0] f, input int n);
        @(posedge clk);
        utxrx_remote_i.send(f, n);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task t_reset;
        rd_chk(`UTXRX_OFF_CSA, 8'h20);
        rd_chk(`UTXRX_OFF_CSB, `UTXRX_CSB_RESET);
        rd_chk(3'h6, 8'h00);
    endtask
    task t_pins;
        @(posedge clk); tx_dir <= 1'b1; tx_bit <= 1'b0; rx_dir <= 1'b1; pull_bit <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK({tx_oe, tx_line, rx_oe, pull}, 4'b1011)
        @(posedge clk); tx_bit <= 1'b1; tx_dir <= 1'b0;
        wr_reg(`UTXRX_OFF_CSB, 8'h18);
        repeat (3) @(posedge clk);
        #1 `CHK({tx_oe, tx_line, rx_oe, pull}, 4'b1101)
        // A low port bit on the idle pin looks like a start bit to the far end
        repeat (160) @(posedge clk);
        utxrx_remote_i.got_q.delete();
    endtask
    task t_tx;
        wr_reg(`UTXRX_OFF_CSB, 8'h78);
        repeat (2) @(posedge clk);
        #1 `CHK(irq_em, 1'b1)
        wr_reg(`UTXRX_OFF_DATA, 8'hA5);
        wait_tx(1);
        fchk(10'h1A5);
        rd_chk(`UTXRX_OFF_CSA, 8'h60);
        `CHK(irq_tx, 1'b1)
        @(posedge clk); ack <= 1'b1;
        @(posedge clk); ack <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(`UTXRX_OFF_CSA, 8'h20);
        wr_reg(`UTXRX_OFF_DATA, 8'h3C);
        wr_reg(`UTXRX_OFF_DATA, 8'hC3);
        rd_chk(`UTXRX_OFF_CSA, 8'h00);
        wait_tx(2);
        fchk(10'h13C);
        fchk(10'h1C3);
        rd_chk(`UTXRX_OFF_CSA, 8'h60);
        wr_reg(`UTXRX_OFF_CSB, 8'h0D);
        nine <= 1'b1;
        wr_reg(`UTXRX_OFF_DATA, 8'h55);
        wait_tx(1);
        fchk(10'h355);
        nine <= 1'b0;
        wr_reg(`UTXRX_OFF_CSA, 8'h40);
        rd_chk(`UTXRX_OFF_CSA, 8'h20);
    endtask
    task t_rx;
        wr_reg(`UTXRX_OFF_CSB, 8'h98);
        rx({2'b01, 8'h96, 1'b0}, 10);
        `CHK(irq_rx, 1'b1)
        rd_chk(`UTXRX_OFF_CSA, 8'hA0);
        rd_chk(`UTXRX_OFF_DATA, 8'h96);
        rd_chk(`UTXRX_OFF_CSA, 8'h20);
        @(posedge clk);
        utxrx_remote_i.spike(3);
        repeat (200) @(posedge clk);
        rd_chk(`UTXRX_OFF_CSA, 8'h20);
        rx({2'b00, 8'h0F, 1'b0}, 10);
        rd_chk(`UTXRX_OFF_CSA, 8'hB0);
        rd_chk(`UTXRX_OFF_DATA, 8'h0F);
        rx({2'b01, 8'hF0, 1'b0}, 10);
        rd_chk(`UTXRX_OFF_CSA, 8'hA0);
        rd_chk(`UTXRX_OFF_DATA, 8'hF0);
    endtask
    task t_filter;
        wr_reg(`UTXRX_OFF_CSB, 8'h14);
        wr_reg(`UTXRX_OFF_CSA, 8'h01);
        rx({2'b10, 8'h5A, 1'b0}, 11);
        rd_chk(`UTXRX_OFF_CSA, 8'h21);
        rx({2'b11, 8'h42, 1'b0}, 11);
        rd_chk(`UTXRX_OFF_CSA, 8'hA1);
        rd_chk(`UTXRX_OFF_CSB, 8'h16);
        rd_chk(`UTXRX_OFF_DATA, 8'h42);
        wr_reg(`UTXRX_OFF_CSB, 8'h10);
        rx({2'b00, 8'h77, 1'b0}, 10);
        rd_chk(`UTXRX_OFF_CSA, 8'h21);
        wr_reg(`UTXRX_OFF_CSA, 8'h00);
    endtask
    task t_overrun;
        rx({2'b01, 8'h11, 1'b0}, 10);
        rx({2'b01, 8'h22, 1'b0}, 10);
        rd_chk(`UTXRX_OFF_CSA, 8'hA0);
        rd_chk(`UTXRX_OFF_DATA, 8'h11);
        rd_chk(`UTXRX_OFF_CSA, 8'h28);
    endtask
    task t_div;
        int n;
        wr_reg(`UTXRX_OFF_CSB, 8'h08);
        wr_reg(`UTXRX_OFF_DIV, 8'h01);
        rd_chk(`UTXRX_OFF_DIV, 8'h01);
        wr_reg(`UTXRX_OFF_DATA, 8'hFF);
        n = 0;
        while (tx_line === 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        while (tx_line === 1'b0 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Divider 16 gives 17 clocks a tick, 16 ticks a bit
        `CHK(n, 17 * `UTXRX_OVERSAMPLE)
        repeat (2480) @(posedge clk);
        rd_chk(`UTXRX_OFF_CSA, 8'h68);
        wr_reg(`UTXRX_OFF_DIV, 8'h00);
    endtask
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; ack = 1'b0; addr = '0; wdata = 8'h00; nine = 1'b0;
        tx_dir = 1'b0; tx_bit = 1'b1; rx_dir = 1'b0; pull_bit = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_pins;
        t_tx;
        t_rx;
        t_filter;
        t_overrun;
        t_div;
        summarize;
    end
endmodule // tb
bind utxrx_top utxrx_monitor utxrx_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tx_done_ack(i_tx_done_ack), .o_rdata(o_rdata),
    .o_tx_port_pin(o_tx_port_pin), .o_tx_pin_oe(o_tx_pin_oe), .o_rx_pin_oe(o_rx_pin_oe),
    .o_irq_rx_done(o_irq_rx_done), .o_irq_tx_done(o_irq_tx_done), .o_irq_tx_empty(o_irq_tx_empty));
`default_nettype wire
